// file: inc/clc_pkg.sv
// closed-loop settings register: shared constants, types and rate table
// assumes a single 25 MHz clock and a classic wishbone register port

// ==========================================================
// package
package clc_pkg;

	// ==========================================================
	// register map
	localparam logic [7:0] CLC_ADDR_SETTINGS_ONE = 8'h88;
	localparam logic [31:0] CLC_SETTINGS_RESET = 32'h0000_0000;
	localparam logic [31:0] CLC_UNMAPPED_READ = 32'h0000_0000;

	// ==========================================================
	// field positions
	localparam int CLC_PARITY_BIT = 31;
	localparam int CLC_OVERMOD_BIT = 30;
	localparam int CLC_ACCEL_MSB = 29;
	localparam int CLC_ACCEL_LSB = 25;
	localparam int CLC_DECEL_SRC_BIT = 24;
	localparam int CLC_DECEL_MSB = 23;
	localparam int CLC_DECEL_LSB = 19;
	localparam int CLC_SURGE_BIT = 3;

	// ==========================================================
	// rates, in units of 0.1 Hz/s; speed in units of 0.1 mHz
	localparam int CLC_RATE_W = 20;
	localparam logic [4:0] CLC_RATE_UNLIMITED = 5'h1F;
	localparam logic [19:0] CLC_RATE_NONE = 20'h0_0000;

	// ==========================================================
	// timing: one ramp step per millisecond
	localparam int CLC_CLOCK_HZ = 25_000_000;
	localparam int CLC_TICK_US = 1000;
	localparam int CLC_TICK_CYCLES = CLC_CLOCK_HZ / 1_000_000 * CLC_TICK_US;

	// ==========================================================
	// ramp direction states
	typedef enum logic [2:0] {
		CLC_HOLD = 3'b001,
		CLC_RISE = 3'b010,
		CLC_FALL = 3'b100
	} clc_ramp_e;

	// code to rate; code 1Fh has no rate and means no limit
	function automatic logic [19:0] clc_rate_lookup(input logic [4:0] code);
		logic [19:0] r;
		r = CLC_RATE_NONE;
		case (code)
			5'h00: r = 20'h0_0005;
			5'h01: r = 20'h0_000A;
			5'h02: r = 20'h0_0019;
			5'h03: r = 20'h0_0032;
			5'h04: r = 20'h0_004B;
			5'h05: r = 20'h0_0064;
			5'h06: r = 20'h0_00C8;
			5'h07: r = 20'h0_0190;
			5'h08: r = 20'h0_0258;
			5'h09: r = 20'h0_0320;
			5'h0A: r = 20'h0_03E8;
			5'h0B: r = 20'h0_07D0;
			5'h0C: r = 20'h0_0BB8;
			5'h0D: r = 20'h0_0FA0;
			5'h0E: r = 20'h0_1388;
			5'h0F: r = 20'h0_1770;
			5'h10: r = 20'h0_1B58;
			5'h11: r = 20'h0_1F40;
			5'h12: r = 20'h0_2328;
			5'h13: r = 20'h0_2710;
			5'h14: r = 20'h0_4E20;
			5'h15: r = 20'h0_9C40;
			5'h16: r = 20'h0_EA60;
			5'h17: r = 20'h1_3880;
			5'h18: r = 20'h1_86A0;
			5'h19: r = 20'h3_0D40;
			5'h1A: r = 20'h4_93E0;
			5'h1B: r = 20'h6_1A80;
			5'h1C: r = 20'h7_A120;
			5'h1D: r = 20'h9_27C0;
			5'h1E: r = 20'hA_AE60;
			default: r = CLC_RATE_NONE;
		endcase
		return r;
	endfunction

endpackage

// file: inc/clc_rate_if.sv
// rate lookup carrier between the settings top and its rate decoders
// assumes both ends sit in the same clock domain

// ==========================================================
// interface
interface clc_rate_if;
	logic [4:0] code;
	logic [19:0] rate;
	logic unlimited;

	modport lookup (
		input code,
		output rate,
		output unlimited
	);

	modport user (
		output code,
		input rate,
		input unlimited
	);
endinterface

// file: testbench/clc_top_tb_top.sv
// self-checking bench for the closed-loop settings register and its ramp
// assumes clc_top with a short tick divider and a classic wishbone port

// ==========================================================
// bench top
module clc_top_tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	// short tick keeps each ramp step to twenty cycles
	localparam int TICKS = 20;
	localparam logic [7:0] ADR = 8'h88;

	logic i_clock = 1'b0;
	logic i_rst_b = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] wdat = 32'h0000_0000;
	logic [31:0] target = 32'h0000_0000;
	logic [31:0] rdat, word, sref, q;
	logic [31:0] last = 32'h0000_0000;
	logic ack, overmod, dec_field, rising, falling;
	int errors = 0;
	int cmp_count = 0;
	int cycles = 0;

	clc_top #(.P_TICK_CYCLES(TICKS)) dut (
		.i_clock(i_clock),
		.i_rst_b(i_rst_b),
		.i_wb_cyc(cyc),
		.i_wb_stb(stb),
		.i_wb_we(we),
		.i_wb_adr(adr),
		.i_wb_sel(sel),
		.i_wb_dat(wdat),
		.i_speed_target(target),
		.o_wb_dat(rdat),
		.o_wb_ack(ack),
		.o_settings_word(word),
		.o_overmod_enable(overmod),
		.o_decel_field_in_use(dec_field),
		.o_speed_ref(sref),
		.o_ramp_rising(rising),
		.o_ramp_falling(falling)
	);

	// ==========================================================
	// clock and hang guard
	always #20 i_clock = ~i_clock;

	// ceiling well above the few hundred cycles the tests need
	always @(posedge i_clock) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			$display("[ERR] timeout expected=done seen=hang");
			close_out();
		end
	end

	// ==========================================================
	// helpers
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %s expected=%h seen=%h", name, exp, seen);
		end
	endtask

	// one classic cycle; request held until ack is sampled high
	task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
			input logic [31:0] d, output logic [31:0] r);
		int n;
		n = 0;
		@(posedge i_clock);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= s;
		wdat <= d;
		do begin
			@(posedge i_clock);
			n++;
		end while (ack !== 1'b1 && n < 50);
		r = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		if (n >= 50) chk("ack", {31'h0, ack}, 32'h0000_0001);
	endtask

	task automatic wr(input logic [31:0] d);
		wb(1'b1, ADR, 4'hF, d, q);
		@(posedge i_clock);
	endtask

	// waits for the next ramp step and checks where it landed
	// measured from the last expected speed, so a step taken early is not skipped
	task automatic step(input logic [31:0] exp);
		int n;
		n = 0;
		do begin
			@(posedge i_clock);
			n++;
		end while (sref === last && n < 3 * TICKS);
		chk("speed_ref", sref, exp);
		last = exp;
	endtask

	task automatic go(input logic [31:0] t);
		@(posedge i_clock);
		target <= t;
	endtask

	task automatic close_out();
		$display("comparisons=%0d mismatches=%0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// ==========================================================
	// main sequence
	initial begin
		repeat (4) @(posedge i_clock);
		i_rst_b <= 1'b1;
		@(posedge i_clock);
		// reset values
		wb(1'b0, ADR, 4'hF, 32'h0, q);
		chk("reset_read", q, 32'h0000_0000);
		chk("reset_word", word, 32'h0000_0000);
		chk("reset_overmod", {31'h0, overmod}, 32'h0);
		chk("reset_dec_field", {31'h0, dec_field}, 32'h1);
		// full word, lanes, unmapped place
		wr(32'hA5C3_5A3C);
		wb(1'b0, ADR, 4'hF, 32'h0, q);
		chk("rw_word", q, 32'hA5C3_5A3C);
		wb(1'b1, ADR, 4'h4, 32'h0077_0000, q);
		wb(1'b1, ADR, 4'h0, 32'hFFFF_FFFF, q);
		wb(1'b1, 8'h8C, 4'hF, 32'hFFFF_FFFF, q);
		wb(1'b0, 8'h8C, 4'hF, 32'h0, q);
		chk("unmapped_read", q, 32'h0000_0000);
		wb(1'b0, ADR, 4'hF, 32'h0, q);
		chk("lane_word", q, 32'hA577_5A3C);
		chk("lane_settings", word, 32'hA577_5A3C);
		// overmodulation enable follows bit 30
		wr(32'h4000_0000);
		chk("overmod_on", {31'h0, overmod}, 32'h1);
		wr(32'h0000_0000);
		chk("overmod_off", {31'h0, overmod}, 32'h0);
		// every accel code is stored and read back
		for (int c = 0; c < 32; c++) begin
			wr({2'b00, c[4:0], 25'h0});
			wb(1'b0, ADR, 4'hF, 32'h0, q);
			chk("accel_code", q, {2'b00, c[4:0], 25'h0});
		end
		// slowest rate, final step clipped at the target
		wr(32'h0000_0000);
		go(32'd12);
		repeat (3) @(posedge i_clock);
		chk("rising", {31'h0, rising}, 32'h1);
		step(32'd5);
		step(32'd10);
		step(32'd12);
		wr(32'h0400_0000);
		go(32'd62);
		step(32'd37);
		step(32'd62);
		// decel at accel rate (10) while the decel field says 5
		wr(32'h0300_0000);
		go(32'd42);
		repeat (3) @(posedge i_clock);
		chk("falling", {31'h0, falling}, 32'h1);
		step(32'd52);
		step(32'd42);
		// decel field rate 10, accel rate 5
		wr(32'h0008_0000);
		chk("dec_field_on", {31'h0, dec_field}, 32'h1);
		go(32'd30);
		step(32'd32);
		step(32'd30);
		// surge guard on: decel field ignored, accel rate 5 used
		wr(32'h0008_0008);
		chk("dec_field_off", {31'h0, dec_field}, 32'h0);
		go(32'd20);
		step(32'd25);
		step(32'd20);
		// unlimited code jumps, top code steps by its full rate
		wr(32'h3E00_0000);
		go(32'h0000_1000);
		step(32'h0000_1000);
		wr(32'h3C00_0000);
		go(32'h0020_0000);
		step(32'h000A_BE60);
		wr(32'h3F00_0000);
		go(32'h0000_0000);
		step(32'h0000_0000);
		close_out();
	end
endmodule

// file: verilog/clc_rate_sel.sv
// registered rate decoder: turns a five-bit rate code into a step size
// assumes the code is stable for a cycle before the rate is used

// ==========================================================
// module
module clc_rate_sel (
	input wire logic i_clock,
	input wire logic i_rst_b,
	clc_rate_if.lookup rate_if
);

	logic [19:0] rate_r;
	logic unlimited_r;

	// table output registered so the ramp adder sees a clean value
	always_ff @(posedge i_clock) begin
		if (!i_rst_b) begin
			rate_r <= clc_pkg::CLC_RATE_NONE;
			unlimited_r <= 1'b0;
		end else begin
			rate_r <= clc_pkg::clc_rate_lookup(rate_if.code);
			unlimited_r <= (rate_if.code == clc_pkg::CLC_RATE_UNLIMITED);
		end
	end

	assign rate_if.rate = rate_r;
	assign rate_if.unlimited = unlimited_r;

	// ==========================================================
	// assertions
	a_top_code_free: assert property (
		@(posedge i_clock) disable iff (!i_rst_b)
		(rate_if.code == clc_pkg::CLC_RATE_UNLIMITED) |=> rate_if.unlimited
	) else $error("code 1Fh did not lift the rate limit");

	a_rate_monotone: assert property (
		@(posedge i_clock) disable iff (!i_rst_b)
		(rate_if.code != 5'h00 && rate_if.code != clc_pkg::CLC_RATE_UNLIMITED)
		|=> (rate_if.rate > clc_pkg::clc_rate_lookup($past(rate_if.code) - 5'h01))
		&& !rate_if.unlimited
	) else $error("rate not above the rate of the code below");

endmodule

// file: verilog/clc_top.sv
// closed-loop settings register with its speed ramp limiter
// assumes a classic wishbone master, one 25 MHz clock, sync active-low reset
//
// Design decision made here: the Wishbone register port.

// ==========================================================
// module
module clc_top #(
	parameter int P_TICK_CYCLES = clc_pkg::CLC_TICK_CYCLES
) (
	input wire logic i_clock,
	input wire logic i_rst_b,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [7:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	input wire logic [31:0] i_speed_target,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	output logic [31:0] o_settings_word,
	output logic o_overmod_enable,
	output logic o_decel_field_in_use,
	output logic [31:0] o_speed_ref,
	output logic o_ramp_rising,
	output logic o_ramp_falling
);

	// ==========================================================
	// bus slave
	logic [31:0] settings_r;
	logic [31:0] settings_nxt;
	logic [31:0] rd_dat_r;
	logic ack_r;
	logic ack_nxt;

	wire req_live = i_wb_cyc && i_wb_stb;
	wire addr_hit = (i_wb_adr == clc_pkg::CLC_ADDR_SETTINGS_ONE);
	wire wr_take = req_live && i_wb_we && ack_r && addr_hit;
	wire rd_load = req_live && !ack_r;
	wire [31:0] rd_value = addr_hit ? settings_r : clc_pkg::CLC_UNMAPPED_READ;

	// byte lanes expanded to a bit mask
	wire [31:0] lane_mask = {{8{i_wb_sel[3]}}, {8{i_wb_sel[2]}},
		{8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};

	// every bit is plain storage, parity included; no check is made on it
	assign settings_nxt = wr_take ? ((settings_r & ~lane_mask) | (i_wb_dat & lane_mask))
		: settings_r;

	// ack one cycle after the request, dropped the cycle after
	assign ack_nxt = req_live && !ack_r;

	// settings word, zero out of reset
	always_ff @(posedge i_clock) begin
		if (!i_rst_b) begin
			settings_r <= clc_pkg::CLC_SETTINGS_RESET;
		end else begin
			settings_r <= settings_nxt;
		end
	end

	// ack and read data; unmapped reads answer zero, writes there vanish
	always_ff @(posedge i_clock) begin
		if (!i_rst_b) begin
			ack_r <= 1'b0;
			rd_dat_r <= clc_pkg::CLC_UNMAPPED_READ;
		end else begin
			ack_r <= ack_nxt;
			if (rd_load) begin
				rd_dat_r <= rd_value;
			end
		end
	end

	assign o_wb_ack = ack_r;
	assign o_wb_dat = rd_dat_r;
	assign o_settings_word = settings_r;

	// ==========================================================
	// field decode
	wire overmod_bit = settings_r[clc_pkg::CLC_OVERMOD_BIT];
	wire decel_source_select = settings_r[clc_pkg::CLC_DECEL_SRC_BIT];
	wire surge_guard_enable = settings_r[clc_pkg::CLC_SURGE_BIT];
	wire [4:0] loop_accel_rate_code =
		settings_r[clc_pkg::CLC_ACCEL_MSB:clc_pkg::CLC_ACCEL_LSB];
	wire [4:0] loop_decel_rate_code =
		settings_r[clc_pkg::CLC_DECEL_MSB:clc_pkg::CLC_DECEL_LSB];

	// overmodulation stays off unless software sets the bit
	assign o_overmod_enable = overmod_bit;

	// decel field only counts with surge guard off and source bit clear
	assign o_decel_field_in_use = !decel_source_select && !surge_guard_enable;

	// ==========================================================
	// rate decoders
	clc_rate_if accel_if ();
	clc_rate_if decel_if ();

	assign accel_if.code = loop_accel_rate_code;
	assign decel_if.code = loop_decel_rate_code;

	clc_rate_sel u_accel_sel (
		.i_clock (i_clock),
		.i_rst_b (i_rst_b),
		.rate_if (accel_if)
	);

	clc_rate_sel u_decel_sel (
		.i_clock (i_clock),
		.i_rst_b (i_rst_b),
		.rate_if (decel_if)
	);

	// falling step: field rate, or accel rate when the field is not in use
	wire fall_unl = o_decel_field_in_use ? decel_if.unlimited
		: accel_if.unlimited;
	wire [19:0] fall_rate = o_decel_field_in_use ? decel_if.rate
		: accel_if.rate;
	wire [31:0] rise_step = {12'h000, accel_if.rate};
	wire [31:0] fall_step = {12'h000, fall_rate};

	// ==========================================================
	// millisecond step divider
	logic [15:0] tick_cnt_r;
	wire tick = (tick_cnt_r == 16'(P_TICK_CYCLES - 1));

	// divider free runs from reset; the ramp moves one step per pulse
	always_ff @(posedge i_clock) begin
		if (!i_rst_b) begin
			tick_cnt_r <= 16'h0000;
		end else if (tick) begin
			tick_cnt_r <= 16'h0000;
		end else begin
			tick_cnt_r <= tick_cnt_r + 16'h0001;
		end
	end

	// ==========================================================
	// speed ramp
	clc_pkg::clc_ramp_e ramp_r;
	clc_pkg::clc_ramp_e ramp_nxt;
	logic [31:0] speed_r;
	logic [31:0] speed_nxt;

	wire up_ok = i_speed_target > speed_r;
	wire dn_ok = i_speed_target < speed_r;
	wire [31:0] gap_up = i_speed_target - speed_r;
	wire [31:0] gap_dn = speed_r - i_speed_target;
	wire rise_snap = accel_if.unlimited || (gap_up <= rise_step);
	wire fall_snap = fall_unl || (gap_dn <= fall_step);

	// direction follows the target; a snapped step never overshoots it
	always_comb begin
		ramp_nxt = clc_pkg::CLC_HOLD;
		if (up_ok) begin
			ramp_nxt = clc_pkg::CLC_RISE;
		end else if (dn_ok) begin
			ramp_nxt = clc_pkg::CLC_FALL;
		end
	end

	// step once per tick; a stale direction after a target jump holds
	always_comb begin
		speed_nxt = speed_r;
		case (ramp_r)
			clc_pkg::CLC_RISE: begin
				if (tick && up_ok) begin
					speed_nxt = rise_snap ? i_speed_target : speed_r + rise_step;
				end
			end
			clc_pkg::CLC_FALL: begin
				if (tick && dn_ok) begin
					speed_nxt = fall_snap ? i_speed_target : speed_r - fall_step;
				end
			end
			clc_pkg::CLC_HOLD: begin
				speed_nxt = speed_r;
			end
			default: begin
				speed_nxt = speed_r;
			end
		endcase
	end

	// ramp registers
	always_ff @(posedge i_clock) begin
		if (!i_rst_b) begin
			ramp_r <= clc_pkg::CLC_HOLD;
			speed_r <= 32'h0000_0000;
		end else begin
			ramp_r <= ramp_nxt;
			speed_r <= speed_nxt;
		end
	end

	assign o_speed_ref = speed_r;
	assign o_ramp_rising = (ramp_r == clc_pkg::CLC_RISE);
	assign o_ramp_falling = (ramp_r == clc_pkg::CLC_FALL);

	// ==========================================================
	// assertions
	a_reset_reads_zero: assert property (
		@(posedge i_clock)
		!i_rst_b |=> (settings_r == 32'h0000_0000) && !o_wb_ack
	) else $error("settings not zero after reset");

	a_read_addr_88: assert property (
		@(posedge i_clock) disable iff (!i_rst_b)
		(rd_load && addr_hit && !i_wb_we) |=> o_wb_ack && (o_wb_dat == $past(settings_r))
	) else $error("read of 88h did not return the settings");

	a_write_full_word: assert property (
		@(posedge i_clock) disable iff (!i_rst_b)
		(wr_take && i_wb_sel == 4'hF) |=> (settings_r == $past(i_wb_dat))
	) else $error("full word write not stored");

	a_write_elsewhere: assert property (
		@(posedge i_clock) disable iff (!i_rst_b)
		(req_live && i_wb_we && ack_r && !addr_hit) |=> $stable(settings_r)
	) else $error("unmapped write changed the settings");

	a_overmod_gate: assert property (
		@(posedge i_clock) disable iff (!i_rst_b)
		(wr_take && i_wb_sel[3]) |=> (o_overmod_enable == $past(i_wb_dat[30]))
	) else $error("overmodulation enable does not follow its bit");

	a_rise_step: assert property (
		@(posedge i_clock) disable iff (!i_rst_b)
		(tick && ramp_r == clc_pkg::CLC_RISE && up_ok && !rise_snap)
		|=> (speed_r == $past(speed_r) + $past(rise_step))
	) else $error("rising step not equal to accel rate");

	a_rise_unlimited: assert property (
		@(posedge i_clock) disable iff (!i_rst_b)
		(tick && ramp_r == clc_pkg::CLC_RISE && up_ok && accel_if.unlimited)
		|=> (speed_r == $past(i_speed_target))
	) else $error("unlimited rise did not reach target");

	a_fall_accel: assert property (
		@(posedge i_clock) disable iff (!i_rst_b)
		(tick && ramp_r == clc_pkg::CLC_FALL && dn_ok && decel_source_select
		&& !accel_if.unlimited && gap_dn > rise_step)
		|=> (speed_r == $past(speed_r) - $past(rise_step))
	) else $error("fall with source bit set not at accel rate");

	a_fall_field: assert property (
		@(posedge i_clock) disable iff (!i_rst_b)
		(tick && ramp_r == clc_pkg::CLC_FALL && dn_ok && o_decel_field_in_use
		&& !decel_if.unlimited && gap_dn > {12'h000, decel_if.rate})
		|=> (speed_r == $past(speed_r) - {12'h000, $past(decel_if.rate)})
	) else $error("fall with source bit clear not at field rate");

	a_surge_blocks_field: assert property (
		@(posedge i_clock) disable iff (!i_rst_b)
		surge_guard_enable |-> !o_decel_field_in_use && (fall_rate == accel_if.rate)
	) else $error("decel field used while surge guard enabled");

	a_unmapped_read_zero: assert property (
		@(posedge i_clock) disable iff (!i_rst_b)
		(rd_load && !addr_hit && !i_wb_we) |=> o_wb_ack && (o_wb_dat == 32'h0000_0000)
	) else $error("read away from 88h did not answer zero");

	a_ack_one_cycle: assert property (
		@(posedge i_clock) disable iff (!i_rst_b)
		o_wb_ack |=> !o_wb_ack
	) else $error("ack held longer than one cycle");

	// ==========================================================
	// covers
	c_write_settings: cover property (
		@(posedge i_clock) disable iff (!i_rst_b)
		wr_take && addr_hit
	);

	c_rise_to_target: cover property (
		@(posedge i_clock) disable iff (!i_rst_b)
		tick && ramp_r == clc_pkg::CLC_RISE && rise_snap ##1 ramp_r == clc_pkg::CLC_HOLD
	);

	c_fall_by_field: cover property (
		@(posedge i_clock) disable iff (!i_rst_b)
		tick && o_ramp_falling && dn_ok && o_decel_field_in_use
	);

	c_rise_unlimited: cover property (
		@(posedge i_clock) disable iff (!i_rst_b)
		tick && o_ramp_rising && up_ok && accel_if.unlimited
	);

	c_fall_by_accel: cover property (
		@(posedge i_clock) disable iff (!i_rst_b)
		tick && o_ramp_falling && dn_ok && decel_source_select
	);

endmodule
